// File: common/rsd_defines.svh
/*
  Constants of the runtime and self-diagnostics block: register offsets,
  field positions, reset values and timing figures.
  Assumes inclusion by bare name from the design; the package does not include it.
*/
`ifndef RSD_DEFINES_SVH
`define RSD_DEFINES_SVH

// ****************************************
// timing
// ****************************************
`define RSD_CLK_HZ 100000000
`define RSD_MS_PER_S 1000
`define RSD_DAY_MS 86400000
`define RSD_COPY_S 120
`define RSD_TEST_S 30
`define RSD_THY_STEPS 12
`define RSD_TREND_MS 1000
`define RSD_BLANK_MS 500
`define RSD_BLINK_FAST_HZ 2
`define RSD_BLINK_SLOW_MS 1000

// ****************************************
// register byte offsets
// ****************************************
`define RSD_REG_RUNTIME_MS 8'h00
`define RSD_REG_RUNTIME_DAYS 8'h04
`define RSD_REG_RELATIVE_MS 8'h08
`define RSD_REG_DIAG_COPY 8'h0C
`define RSD_REG_TREND_CTRL 8'h10
`define RSD_REG_TREND_LIMIT 8'h14
`define RSD_REG_THY_SELECT 8'h18
`define RSD_REG_DRIVE_STATE 8'h1C
`define RSD_REG_FAULT_VALUE 8'h20
`define RSD_REG_STAMP_MS 8'h24
`define RSD_REG_STAMP_DAYS 8'h28
`define RSD_REG_LED_CTRL 8'h2C
`define RSD_REG_IRQ_STATUS 8'h30
`define RSD_REG_IRQ_ENABLE 8'h34
`define RSD_REG_IRQ_CLEAR 8'h38

// ****************************************
// fields and reset values
// ****************************************
`define RSD_LED_MODE_LSB 0
`define RSD_LED_CAUSE_LSB 4
`define RSD_LED_SOFT_LSB 8
`define RSD_IRQ_COPY_DONE 0
`define RSD_IRQ_TREND_STOP 1
`define RSD_IRQ_THY_FAULT 2
`define RSD_IRQ_DAY_WRAP 3
`define RSD_CODE_INHIBIT 4'h7
`define RSD_CODE_TEST 4'h3
`define RSD_CODE_RUN 4'h0
`define RSD_CAUSE_BLOCKING 2'h1
`define RSD_CAUSE_TRIGGER 2'h2
`define RSD_TREND_LIMIT_RST 16'h0064
`define RSD_THY_SELECT_RST 2'h0

`endif

// File: common/rsd_pkg.sv
/*
  Types of the runtime and self-diagnostics block.
  Does not include rsd_defines.svh and uses none of its defines.
*/
package rsd_pkg;

  // ****************************************
  // enumerations
  // ****************************************
  typedef enum logic [1:0] {
    DRV_INHIBIT = 2'b00,
    DRV_BLOCK = 2'b01,
    DRV_TRIGGER = 2'b10,
    DRV_RUN = 2'b11
  } rsd_drive_t;

  typedef enum logic [2:0] {
    LM_RAMP_INIT = 3'b000,
    LM_RAMP_ERR = 3'b001,
    LM_RAMP_OK = 3'b010,
    LM_UPD_BUSY = 3'b011,
    LM_UPD_BAD = 3'b100,
    LM_UPD_OK = 3'b101,
    LM_UPD_FOREIGN = 3'b110,
    LM_LINK_UPD = 3'b111
  } rsd_led_mode_t;

  typedef enum logic [1:0] {
    LC_OFF = 2'b00,
    LC_GREEN = 2'b01,
    LC_RED = 2'b10,
    LC_ORANGE = 2'b11
  } rsd_color_t;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    rsd_color_t readyLed;
    rsd_color_t fieldbusLed;
    rsd_color_t optionLed;
    rsd_color_t moduleLed;
  } rsd_led_t;

  typedef logic [3:0][15:0] rsd_chan_t;

  typedef struct packed {
    logic [31:0] days;
    logic [31:0] ms;
    rsd_chan_t chan;
  } rsd_trend_t;

  // ****************************************
  // module state
  // ****************************************
  typedef struct packed {
    logic waitReq;
    logic [31:0] rdData;
    logic [31:0] msPre;
    logic [31:0] msCount;
    logic [31:0] dayCount;
    logic [31:0] relMs;
    logic loaded;
    logic [2:0] pfSync;
    logic nvSave;
    logic [31:0] nvSaveDays;
    logic diagCopy;
    logic [31:0] copyMs;
    logic [1:0] trendMode;
    logic [15:0] trendLimit;
    logic [15:0] trendIdx;
    logic [31:0] trendMs;
    logic trendValid;
    rsd_trend_t trendLine;
    logic [1:0] thySelect;
    logic firstOnDone;
    rsd_drive_t drv;
    logic [3:0] dispCode;
    logic [2:0] stepIdx;
    logic [31:0] stepMs;
    logic [5:0] fire;
    logic [2:0] onSync;
    logic thyFault;
    logic [7:0] faultValue;
    logic [31:0] stampMs;
    logic [31:0] stampDays;
    rsd_led_mode_t ledMode;
    logic [1:0] ledCause;
    logic [7:0] ledSoft;
    logic [31:0] blankMs;
    logic [31:0] fastMs;
    logic [31:0] slowMs;
    logic fastPh;
    logic slowPh;
    rsd_led_t leds;
    logic [3:0] irqStatus;
    logic [3:0] irqEnable;
    logic irq;
  } rsd_state_t;

endpackage

// File: hdl/rsd_runtime_diag.sv
/*
  Runtime counters, diagnostics-file copy, trend recorder, thyristor
  self-test sequencer and status LED encoder, behind an Avalon-MM slave.
  Assumes pins powerDown and switchOn are asynchronous; all other inputs
  come from logic on mclk.
*/
// Function
// - millisecond runtime counts up and returns to zero after one full day
// - day count kept in persistent memory at power-down, resumed at power-up
// - separate millisecond counter since power-on, wrapping after ~49 days
// - fault entries carry a timestamp from the system runtime counter
// - writing one starts diag copy; device clears it when copy finishes
// - trend recorder samples four channels, each line with runtime stamp
// - control value one stops at the entry limit and resets control to zero
// - control value two overwrites oldest entries until software writes zero
// - test select: never, first on, every on, next on then self-clear
// - switch-on goes inhibit to run, holding test-wait during the test
// - full thyristor self-test lasts about thirty seconds
// - blocking phase fires each thyristor alone; any current is a fault
// - trigger phase fires pairs; under five percent rated current fails
// - test fault raises fault message with value naming thyristor and cause
// - ramp-up error shows the cause on the LEDs and locks LED control until reset
// - after good ramp-up all LEDs briefly off, then software controls them
// - software update LED codes with option and module LEDs off
// - drive-link update: ready orange 0.5 Hz, 2 Hz when done, module off
`timescale 1ns/1ps
`include "rsd_defines.svh"

module rsd_runtime_diag
  import rsd_pkg::*;
#(
  parameter int P_MS_CYCLES = `RSD_CLK_HZ / `RSD_MS_PER_S,
  parameter int P_DAY_MS = `RSD_DAY_MS,
  parameter int P_COPY_MS = `RSD_COPY_S * `RSD_MS_PER_S,
  parameter int P_STEP_MS = `RSD_TEST_S * `RSD_MS_PER_S / `RSD_THY_STEPS,
  parameter int P_TREND_MS = `RSD_TREND_MS,
  parameter int P_BLANK_MS = `RSD_BLANK_MS,
  parameter int P_FAST_MS = `RSD_MS_PER_S / (2 * `RSD_BLINK_FAST_HZ),
  parameter int P_SLOW_MS = `RSD_BLINK_SLOW_MS
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // register bus
  input wire logic [7:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  // persistent day store
  input wire logic [31:0] nvDays,
  input wire logic powerDown,
  output logic nvSave,
  output logic [31:0] nvSaveDays,
  // power unit
  input wire logic switchOn,
  input wire logic [15:0] armCurrent,
  input wire logic [15:0] ratedCurrentReference,
  output logic [5:0] thyFire,
  output logic [3:0] driveStateDisplay,
  output logic thyristorFaultMessage,
  output logic [7:0] faultValue,
  // trend recorder
  input wire rsd_chan_t trendIn,
  output logic trendValid,
  output rsd_trend_t trendLine,
  // indicators
  output rsd_led_t leds,
  output logic irq
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [5:0] oneHot(input logic [2:0] i);
    oneHot = 6'h01 << i;
  endfunction

  function automatic logic [31:0] mergeBe(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    for (int b = 0; b < 4; b++)
    begin
      old[b*8 +: 8] = be[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
    end
    mergeBe = old;
  endfunction

  function automatic logic [3:0] stateCode(input rsd_drive_t d);
    case (d)
      DRV_INHIBIT: stateCode = `RSD_CODE_INHIBIT;
      DRV_BLOCK: stateCode = `RSD_CODE_TEST;
      DRV_TRIGGER: stateCode = `RSD_CODE_TEST;
      DRV_RUN: stateCode = `RSD_CODE_RUN;
      default: stateCode = `RSD_CODE_INHIBIT;
    endcase
  endfunction

  function automatic rsd_led_t ledDecode(input rsd_state_t s);
    rsd_color_t fr;
    rsd_color_t sr;
    fr = s.fastPh ? LC_RED : LC_OFF;
    sr = s.slowPh ? LC_RED : LC_OFF;
    ledDecode = '{LC_OFF, LC_OFF, LC_OFF, LC_OFF};
    case (s.ledMode)
      LM_RAMP_INIT: ledDecode.readyLed = LC_ORANGE;
      LM_RAMP_ERR:
      begin
        case (s.ledCause)
          2'h0: ledDecode = '{fr, LC_RED, LC_OFF, LC_OFF};
          2'h1: ledDecode = '{fr, fr, LC_OFF, LC_OFF};
          default: ledDecode = '{sr, sr, LC_OFF, LC_OFF};
        endcase
      end
      LM_RAMP_OK:
      begin
        if (s.blankMs >= 32'(P_BLANK_MS))
          ledDecode = rsd_led_t'(s.ledSoft);
      end
      LM_UPD_BUSY: ledDecode.readyLed = LC_RED;
      LM_UPD_BAD: ledDecode = '{fr, LC_RED, LC_OFF, LC_OFF};
      LM_UPD_OK: ledDecode = '{sr, sr, LC_OFF, LC_OFF};
      LM_UPD_FOREIGN: ledDecode = '{fr, fr, LC_OFF, LC_OFF};
      LM_LINK_UPD:
      begin
        if (s.ledCause[0] ? s.fastPh : s.slowPh)
          ledDecode.readyLed = LC_ORANGE;
      end
      default: ledDecode = '{LC_OFF, LC_OFF, LC_OFF, LC_OFF};
    endcase
  endfunction

  function automatic logic [31:0] readReg(input rsd_state_t s,
      input logic [7:0] a);
    case (a & 8'hFC)
      `RSD_REG_RUNTIME_MS: readReg = s.msCount;
      `RSD_REG_RUNTIME_DAYS: readReg = s.dayCount;
      `RSD_REG_RELATIVE_MS: readReg = s.relMs;
      `RSD_REG_DIAG_COPY: readReg = {31'h0, s.diagCopy};
      `RSD_REG_TREND_CTRL: readReg = {30'h0, s.trendMode};
      `RSD_REG_TREND_LIMIT: readReg = {16'h0, s.trendLimit};
      `RSD_REG_THY_SELECT: readReg = {30'h0, s.thySelect};
      `RSD_REG_DRIVE_STATE: readReg = {28'h0, s.dispCode};
      `RSD_REG_FAULT_VALUE: readReg = {23'h0, s.thyFault, s.faultValue};
      `RSD_REG_STAMP_MS: readReg = s.stampMs;
      `RSD_REG_STAMP_DAYS: readReg = s.stampDays;
      `RSD_REG_LED_CTRL: readReg = {16'h0, s.ledSoft, 2'h0, s.ledCause,
        1'b0, s.ledMode};
      `RSD_REG_IRQ_STATUS: readReg = {28'h0, s.irqStatus};
      `RSD_REG_IRQ_ENABLE: readReg = {28'h0, s.irqEnable};
      default: readReg = 32'h0000_0000;
    endcase
  endfunction

  // ****************************************
  // state
  // ****************************************
  rsd_state_t st;
  rsd_state_t next_st;
  logic msTick;
  logic wrHit;
  logic [31:0] wd;
  logic [3:0] events;
  logic onRise;
  logic stepEnd;
  logic blockFail;
  logic trigFail;
  logic doTest;

  assign msTick = st.msPre == 32'(P_MS_CYCLES - 1);
  assign wrHit = avsWrite && !st.waitReq;
  assign onRise = st.onSync[1] && !st.onSync[2];
  assign stepEnd = msTick && st.stepMs == 32'(P_STEP_MS - 1);
  assign blockFail = armCurrent != 16'h0000;
  assign trigFail = ({16'h0, armCurrent} * 32'h0000_0014) <
    {16'h0, ratedCurrentReference};

  always_comb
  begin
    next_st = st;
    events = 4'h0;
    wd = mergeBe(readReg(st, avsAddress), avsWritedata, avsByteenable);
    doTest = 1'b0;
    next_st.trendValid = 1'b0;
    next_st.nvSave = 1'b0;
    // bus slave: one wait cycle, then answer for one cycle
    next_st.waitReq = 1'b1;
    if ((avsRead || avsWrite) && st.waitReq)
    begin
      next_st.waitReq = 1'b0;
      next_st.rdData = avsRead ? readReg(st, avsAddress) : 32'h0000_0000;
    end
    // runtime counters
    next_st.msPre = msTick ? 32'h0000_0000 : st.msPre + 32'h0000_0001;
    if (msTick)
    begin
      next_st.relMs = st.relMs + 32'h0000_0001;
      if (st.msCount == 32'(P_DAY_MS - 1))
      begin
        next_st.msCount = 32'h0000_0000;
        next_st.dayCount = st.dayCount + 32'h0000_0001;
        events[`RSD_IRQ_DAY_WRAP] = 1'b1;
      end
      else
        next_st.msCount = st.msCount + 32'h0000_0001;
    end
    next_st.loaded = 1'b1;
    if (!st.loaded)
      next_st.dayCount = nvDays;
    next_st.pfSync = {st.pfSync[1:0], powerDown};
    if (st.pfSync[1] && !st.pfSync[2])
    begin
      next_st.nvSave = 1'b1;
      next_st.nvSaveDays = st.dayCount;
    end
    // diagnostics copy
    if (st.diagCopy && msTick)
    begin
      next_st.copyMs = st.copyMs + 32'h0000_0001;
      if (st.copyMs == 32'(P_COPY_MS - 1))
      begin
        next_st.diagCopy = 1'b0;
        events[`RSD_IRQ_COPY_DONE] = 1'b1;
      end
    end
    // trend recorder
    if (st.trendMode != 2'h0 && msTick)
    begin
      next_st.trendMs = st.trendMs + 32'h0000_0001;
      if (st.trendMs == 32'(P_TREND_MS - 1))
      begin
        next_st.trendMs = 32'h0000_0000;
        next_st.trendValid = 1'b1;
        next_st.trendLine = '{st.dayCount, st.msCount, trendIn};
        next_st.trendIdx = st.trendIdx + 16'h0001;
        if (st.trendIdx + 16'h0001 >= st.trendLimit)
        begin
          if (st.trendMode == 2'h1)
          begin
            next_st.trendMode = 2'h0;
            events[`RSD_IRQ_TREND_STOP] = 1'b1;
          end
          else
            next_st.trendIdx = 16'h0000;
        end
      end
    end
    // thyristor test sequencer
    next_st.onSync = {st.onSync[1:0], switchOn};
    case (st.drv)
      DRV_INHIBIT:
      begin
        if (onRise)
        begin
          doTest = st.thySelect == 2'h2 || st.thySelect == 2'h3 ||
            (st.thySelect == 2'h1 && !st.firstOnDone);
          next_st.firstOnDone = 1'b1;
          if (st.thySelect == 2'h3)
            next_st.thySelect = 2'h0;
          next_st.stepIdx = 3'h0;
          next_st.stepMs = 32'h0000_0000;
          next_st.fire = doTest ? oneHot(3'h0) : 6'h00;
          next_st.drv = doTest ? DRV_BLOCK : DRV_RUN;
        end
      end
      DRV_BLOCK, DRV_TRIGGER:
      begin
        if (msTick)
          next_st.stepMs = st.stepMs + 32'h0000_0001;
        if (!st.onSync[1])
        begin
          next_st.drv = DRV_INHIBIT;
          next_st.fire = 6'h00;
        end
        else if (stepEnd)
        begin
          next_st.stepMs = 32'h0000_0000;
          if (st.drv == DRV_BLOCK ? blockFail : trigFail)
          begin
            next_st.thyFault = 1'b1;
            next_st.faultValue = {st.drv == DRV_TRIGGER, 2'(st.drv == DRV_BLOCK
              ? `RSD_CAUSE_BLOCKING : `RSD_CAUSE_TRIGGER), 2'h0,
              st.stepIdx};
            next_st.stampMs = st.msCount;
            next_st.stampDays = st.dayCount;
            events[`RSD_IRQ_THY_FAULT] = 1'b1;
            next_st.fire = 6'h00;
            next_st.drv = DRV_INHIBIT;
          end
          else if (st.stepIdx == 3'h5)
          begin
            next_st.stepIdx = 3'h0;
            next_st.drv = st.drv == DRV_BLOCK ? DRV_TRIGGER : DRV_RUN;
            next_st.fire = st.drv == DRV_BLOCK ?
              (oneHot(3'h0) | oneHot(3'h1)) : 6'h00;
          end
          else
          begin
            next_st.stepIdx = st.stepIdx + 3'h1;
            next_st.fire = st.drv == DRV_BLOCK ?
              oneHot(st.stepIdx + 3'h1) :
              (oneHot(st.stepIdx + 3'h1) |
              oneHot(st.stepIdx == 3'h4 ? 3'h0 : st.stepIdx + 3'h2));
          end
        end
      end
      DRV_RUN:
      begin
        if (!st.onSync[1])
          next_st.drv = DRV_INHIBIT;
      end
      default: next_st.drv = DRV_INHIBIT;
    endcase
    next_st.dispCode = stateCode(next_st.drv);
    // indicators
    next_st.fastMs = msTick ? st.fastMs + 32'h0000_0001 : st.fastMs;
    next_st.slowMs = msTick ? st.slowMs + 32'h0000_0001 : st.slowMs;
    if (msTick && st.fastMs == 32'(P_FAST_MS - 1))
    begin
      next_st.fastMs = 32'h0000_0000;
      next_st.fastPh = !st.fastPh;
    end
    if (msTick && st.slowMs == 32'(P_SLOW_MS - 1))
    begin
      next_st.slowMs = 32'h0000_0000;
      next_st.slowPh = !st.slowPh;
    end
    if (msTick && st.blankMs < 32'(P_BLANK_MS))
      next_st.blankMs = st.blankMs + 32'h0000_0001;
    // register writes; a software set wins over a hardware clear
    if (wrHit)
    begin
      case (avsAddress & 8'hFC)
        `RSD_REG_DIAG_COPY:
        begin
          next_st.diagCopy = wd[0];
          next_st.copyMs = 32'h0000_0000;
        end
        `RSD_REG_TREND_CTRL:
        begin
          next_st.trendMode = wd[1:0] == 2'h3 ? 2'h0 : wd[1:0];
          next_st.trendIdx = 16'h0000;
          next_st.trendMs = 32'h0000_0000;
        end
        `RSD_REG_TREND_LIMIT: next_st.trendLimit = wd[15:0];
        `RSD_REG_THY_SELECT: next_st.thySelect = wd[1:0];
        `RSD_REG_LED_CTRL:
        begin
          if (st.ledMode != LM_RAMP_ERR)
          begin
            next_st.ledMode = rsd_led_mode_t'(wd[`RSD_LED_MODE_LSB +: 3]);
            next_st.ledCause = wd[`RSD_LED_CAUSE_LSB +: 2];
            next_st.ledSoft = wd[`RSD_LED_SOFT_LSB +: 8];
            if (wd[`RSD_LED_MODE_LSB +: 3] == LM_RAMP_OK &&
              st.ledMode != LM_RAMP_OK)
              next_st.blankMs = 32'h0000_0000;
          end
        end
        `RSD_REG_IRQ_ENABLE: next_st.irqEnable = wd[3:0];
        `RSD_REG_IRQ_CLEAR: next_st.irqStatus = st.irqStatus & ~wd[3:0];
        default: next_st.irqEnable = st.irqEnable;
      endcase
    end
    next_st.irqStatus = next_st.irqStatus | events;
    next_st.irq = |(next_st.irqStatus & next_st.irqEnable);
    next_st.leds = ledDecode(next_st);
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st <= '0;
      st.waitReq <= 1'b1;
      st.trendLimit <= `RSD_TREND_LIMIT_RST;
      st.thySelect <= `RSD_THY_SELECT_RST;
      st.dispCode <= `RSD_CODE_INHIBIT;
      st.leds <= '{LC_ORANGE, LC_OFF, LC_OFF, LC_OFF};
    end
    else
      st <= next_st;
  end

  assign avsReaddata = st.rdData;
  assign avsWaitrequest = st.waitReq;
  assign nvSave = st.nvSave;
  assign nvSaveDays = st.nvSaveDays;
  assign thyFire = st.fire;
  assign driveStateDisplay = st.dispCode;
  assign thyristorFaultMessage = st.thyFault;
  assign faultValue = st.faultValue;
  assign trendValid = st.trendValid;
  assign trendLine = st.trendLine;
  assign leds = st.leds;
  assign irq = st.irq;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_ms_day_wrap: assert property (
    msTick && st.msCount == 32'(P_DAY_MS - 1) && st.loaded |=>
    st.msCount == 32'h0 && st.dayCount == $past(st.dayCount) + 32'h1)
    else $error("runtime day wrap wrong");
  a_day_hold: assert property (
    st.loaded && !(msTick && st.msCount == 32'(P_DAY_MS - 1)) |=>
    $stable(st.dayCount))
    else $error("day count moved without wrap");
  a_rel_count: assert property (
    msTick |=> st.relMs == $past(st.relMs) + 32'h1)
    else $error("relative runtime not counting");
  a_fault_stamp: assert property (
    $rose(st.thyFault) |-> st.stampMs == $past(st.msCount))
    else $error("fault stamp mismatch");
  a_copy_clear: assert property (
    st.diagCopy && msTick && st.copyMs == 32'(P_COPY_MS - 1) && !wrHit
    |=> !st.diagCopy)
    else $error("diag copy not cleared");
  a_trend_stop: assert property (
    st.trendMode == 2'h1 && msTick && st.trendMs == 32'(P_TREND_MS - 1) &&
    st.trendIdx + 16'h1 >= st.trendLimit && !wrHit |=>
    st.trendMode == 2'h0 && st.trendValid)
    else $error("one-shot trend did not stop");
  a_trend_ring: assert property (
    st.trendMode == 2'h2 && !wrHit |=> st.trendMode == 2'h2)
    else $error("ring trend stopped by itself");
  a_sel_clear: assert property (
    st.drv == DRV_INHIBIT && onRise && st.thySelect == 2'h3 && !wrHit |=>
    st.thySelect == 2'h0 && st.drv == DRV_BLOCK)
    else $error("select three not cleared");
  a_test_wait: assert property (
    st.drv == DRV_BLOCK || st.drv == DRV_TRIGGER |-> st.dispCode ==
    `RSD_CODE_TEST)
    else $error("test state not shown");
  a_block_fire: assert property (
    st.drv == DRV_BLOCK |-> $onehot(st.fire))
    else $error("blocking phase fired more than one");
  a_trig_pair: assert property (
    st.drv == DRV_TRIGGER |-> $countones(st.fire) == 2)
    else $error("trigger phase not a pair");
  a_irq_level: assert property (
    irq == |(st.irqStatus & st.irqEnable))
    else $error("interrupt not following cause");

  c_copy_done: cover property ($fell(st.diagCopy));
  c_trend_stop: cover property (st.trendValid && st.trendMode == 2'h0);
  c_thy_fault: cover property ($rose(st.thyFault));
  c_test_pass: cover property (st.drv == DRV_TRIGGER ##1 st.drv == DRV_RUN);

endmodule // rsd_runtime_diag

// File: test/rsd_runtime_diag_bench.sv
/*
  Self-checking bench of the runtime and self-diagnostics block.
  Assumes rsd_pkg and rsd_runtime_diag compiled before it.
*/
`timescale 1ns/1ps

module rsd_runtime_diag_bench
  import rsd_pkg::*;
;
  logic mclk;
  logic rst_b;
  logic [7:0] avsAddress;
  logic avsRead;
  logic avsWrite;
  logic [31:0] avsWritedata;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic powerDown;
  logic nvSave;
  logic [31:0] nvSaveDays;
  logic switchOn;
  logic [15:0] armCurrent;
  logic [15:0] ratedRef;
  logic [3:0] driveState;
  logic thyFaultMsg;
  logic [7:0] faultValue;
  logic trendValid;
  rsd_led_t leds;
  logic irq;
  logic [3:0] avsByteenable;
  logic [31:0] nvStore;
  logic [5:0] thyFire;
  rsd_chan_t trendIn;
  rsd_trend_t trendLine;
  rsd_trend_t lastLine;
  localparam int MSC = 10, DAYMS = 20, COPYMS = 5, STEPMS = 3;
  localparam int TRENDMS = 3, BLANKMS = 4, FASTMS = 2, SLOWMS = 4;
  logic [31:0] q;
  logic [31:0] d0;
  int num_errors;
  int num_checks;
  int trendCnt;
  int cyc;

  rsd_runtime_diag #(.P_MS_CYCLES(MSC), .P_DAY_MS(DAYMS),
    .P_COPY_MS(COPYMS), .P_STEP_MS(STEPMS), .P_TREND_MS(TRENDMS),
    .P_BLANK_MS(BLANKMS), .P_FAST_MS(FASTMS), .P_SLOW_MS(SLOWMS))
    dut_u (.mclk(mclk), .rst_b(rst_b),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .nvDays(nvStore), .powerDown(powerDown), .nvSave(nvSave),
    .nvSaveDays(nvSaveDays), .switchOn(switchOn), .armCurrent(armCurrent),
    .ratedCurrentReference(ratedRef), .thyFire(thyFire),
    .driveStateDisplay(driveState), .thyristorFaultMessage(thyFaultMsg),
    .faultValue(faultValue), .trendIn(trendIn),
    .trendValid(trendValid), .trendLine(trendLine), .leds(leds), .irq(irq));

  // ****************************************
  // clock, watchdog, shared tasks
  // ****************************************
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (trendValid === 1'b1)
    begin
      trendCnt++;
      lastLine = trendLine;
    end
    if (cyc == 20000)
    begin
      num_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      test_done;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // hold request until waitrequest sampled low, then release
  task rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWritedata <= d;
    @(posedge mclk);
    while (avsWaitrequest !== 1'b0)
      @(posedge mclk);
    q = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge mclk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    rw(0, 8'h1C, 0);
    chk(q, 32'h7);
    rw(0, 8'h04, 0);
    chk(q, 32'h5);
    rw(0, 8'h3C, 0);
    chk(q, 32'h0);
    $display("reset test done");
  endtask

  task t_time;
    rw(0, 8'h04, 0);
    d0 = q;
    repeat (200) @(posedge mclk);
    rw(0, 8'h04, 0);
    chk(32'(q - d0 == 1 || q - d0 == 2), 32'h1);
    rw(0, 8'h00, 0);
    chk(32'(q < 20), 32'h1);
    rw(0, 8'h08, 0);
    d0 = q;
    repeat (100) @(posedge mclk);
    rw(0, 8'h08, 0);
    chk(32'(q - d0 >= 10 && q - d0 <= 12), 32'h1);
    powerDown <= 1'b1;
    while (nvSave !== 1'b1)
      @(posedge mclk);
    chk(32'(nvSaveDays > 5), 32'h1);
    $display("runtime test done");
  endtask

  task t_copy;
    rw(1, 8'h34, 32'h1);
    rw(1, 8'h0C, 32'h1);
    rw(0, 8'h0C, 0);
    chk(q, 32'h1);
    repeat (70) @(posedge mclk);
    rw(0, 8'h0C, 0);
    chk(q, 32'h0);
    chk(32'(irq), 32'h1);
    rw(1, 8'h38, 32'h1);
    chk(32'(irq), 32'h0);
    $display("copy test done");
  endtask

  task t_trend;
    avsByteenable <= 4'h1;
    rw(1, 8'h14, 32'h0302);
    avsByteenable <= 4'hF;
    rw(0, 8'h14, 0);
    chk(q, 32'h2);
    trendCnt = 0;
    rw(1, 8'h10, 32'h1);
    repeat (100) @(posedge mclk);
    chk(32'(trendCnt), 32'h2);
    rw(0, 8'h10, 0);
    chk(q, 32'h0);
    rw(1, 8'h10, 32'h2);
    repeat (150) @(posedge mclk);
    rw(0, 8'h10, 0);
    chk(q, 32'h2);
    chk(32'(trendCnt > 5), 32'h1);
    chk(32'(lastLine.chan[3]), 32'h4);
    chk(32'(lastLine.chan[0]), 32'h1);
    rw(1, 8'h10, 32'h0);
    $display("trend test done");
  endtask

  task t_thy;
    rw(1, 8'h18, 32'h3);
    switchOn <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(32'(driveState), 32'h3);
    chk(32'(thyFire), 32'h1);
    repeat (300) @(posedge mclk);
    chk(32'(driveState), 32'h3);
    repeat (80) @(posedge mclk);
    chk(32'(driveState), 32'h0);
    rw(0, 8'h18, 0);
    chk(q, 32'h0);
    switchOn <= 1'b0;
    rw(1, 8'h18, 32'h2);
    ratedRef <= 16'h0064;
    switchOn <= 1'b1;
    repeat (380) @(posedge mclk);
    chk(32'(thyFaultMsg), 32'h1);
    chk(32'(faultValue[6:5]), 32'h2);
    chk(32'(driveState), 32'h7);
    switchOn <= 1'b0;
    armCurrent <= 16'h0001;
    repeat (5) @(posedge mclk);
    switchOn <= 1'b1;
    repeat (40) @(posedge mclk);
    chk(32'(faultValue), 32'h20);
    switchOn <= 1'b0;
    $display("thyristor test done");
  endtask

  task t_led;
    rw(1, 8'h2C, 32'h3);
    chk(32'(leds), 32'h80);
    rw(1, 8'h2C, 32'h0000_A502);
    chk(32'(leds), 32'h0);
    repeat (50) @(posedge mclk);
    chk(32'(leds), 32'hA5);
    rw(1, 8'h2C, 32'h17);
    d0 = 32'(leds);
    repeat (20) @(posedge mclk);
    chk(32'(leds) ^ d0, 32'hC0);
    rw(1, 8'h2C, 32'h1);
    chk(32'(leds[5:0]), 32'h20);
    rw(1, 8'h2C, 32'h3);
    rw(0, 8'h2C, 0);
    chk(q, 32'h1);
    $display("led test done");
  endtask

  initial
  begin
    rst_b = 1'b0;
    avsAddress = 8'h0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWritedata = 32'h0;
    powerDown = 1'b0;
    switchOn = 1'b0;
    armCurrent = 16'h0;
    ratedRef = 16'h0;
    avsByteenable = 4'hF;
    nvStore = 32'h5;
    trendIn = 64'h0004_0003_0002_0001;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    t_reset;
    t_time;
    t_copy;
    t_trend;
    t_thy;
    t_led;
    test_done;
  end
endmodule // rsd_runtime_diag_bench
